// [src/mce_maint_core.v]
`timescale 1ns/100ps
`include "mce_consts.vh"

// Contract
// RULE1 - Triple-confirmed M4 change reaches FSM at once
// RULE2 - Overhead reports only after full superframe
// RULE3 - Shared filter with CRC delays FSM superframe
// RULE4 - Tx mask zero sends commanded M4 bit
// RULE5 - Tx mask bit 6 and ST_ACTIVITY_BIT control
// RULE6 - No ST_ACTIVITY_BIT control during local loop; SAICTL writes to tx mask bit 6 are not gated by any loop state here
// RULE7 - Rx mask gates overhead change reports
// RULE8 - Rx mask bit 6 forces ST_ACTIVITY_BIT to one
// RULE9 - Commanded M4 from next superframe; report validated
// RULE10 - Spare M5/M6 writable, received ones reported
// RULE11 - Reports only in synchronized line states
// RULE12 - EOC in M1-M3, two messages per superframe
// RULE13 - Address, indicator, eight-bit information field
// RULE14 - Indicator one means message code
// RULE15 - Eight supported EOC message codes
// RULE16 - Repeated command and triple echo protocol
// RULE17 - EOC bits high without superframe
// RULE18 - Downstream EOC command repeated every slot
// RULE19 - Auto mode: no echo, latch, action
// RULE20 - Auto mode reports matching echo always; the code reports an echo only on its third consecutive copy (eoc_conf)
// RULE21 - Others reported confirmed and changed only
// RULE22 - Transparent reports every message unconfirmed
// RULE23 - Filter EOC field selects processing mode
// RULE24 - Triple confirmation needs three consecutive
// RULE25 - Filter bit 5 selects FSM validation
// RULE26 - CRC-covered reports delayed one superframe
module mce_maint_core (
	// AHB-Lite slave
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire        hreadyout,
	output wire        hresp,
	output wire [31:0] hrdata,
	// Straps
	input  wire        auto_pin,
	input  wire        crcon_pin,
	// Frame side
	input  wire        bf_strobe,
	input  wire [2:0]  bf_idx,
	input  wire [5:0]  rx_mbits,
	input  wire        crc_ok,
	input  wire [3:0]  line_state,
	input  wire [7:0]  fsm_tx_m4,
	output reg  [5:0]  tx_mbits_r,
	output reg  [7:0]  fsm_rx_m4_r,
	// Monitor reports
	output reg         ob_msg_valid_r,
	output reg  [11:0] ob_msg_data_r,
	output reg         eoc_msg_valid_r,
	output reg  [11:0] eoc_msg_data_r
);

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	function in_sync;
		input [3:0] s;
		begin
			in_sync = (s == `MCE_ST_ACTIVE) || (s == `MCE_ST_PENDTR) ||
				(s == `MCE_ST_STDEACT) || (s == `MCE_ST_PENDDEA) ||
				(s == `MCE_ST_TRANSP);
		end
	endfunction

	function [1:0] sat_inc;
		input [1:0] c;
		begin
			sat_inc = (c == `MCE_TLL_CNT) ? c : c + 2'h1;
		end
	endfunction

	function [2:0] trip;
		input [11:0] m;
		input [1:0]  k;
		begin
			case (k)
			2'h0:    trip = m[11:9];
			2'h1:    trip = m[8:6];
			2'h2:    trip = m[5:3];
			default: trip = m[2:0];
			endcase
		end
	endfunction

	function [7:0] ob_m4;
		input [11:0] d;
		begin
			ob_m4 = {d[0], d[1], d[2], d[3], d[4], d[5], d[8], d[11]};
		end
	endfunction

	function [11:0] ob_pack;
		input [7:0] m4;
		input [2:0] m56;
		begin
			ob_pack = {m4[0], m56[0], m56[2], m4[1], m56[1], 1'b1,
				m4[2], m4[3], m4[4], m4[5], m4[6], m4[7]};
		end
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	reg        strap_done_r;
	reg [7:0]  filt_r;
	reg [7:0]  txmask_r;
	reg [7:0]  rxmask_r;
	reg [11:0] ob_cmd_r;
	reg [11:0] eoc_cmd_r;
	reg        eoc_new_r;
	reg        eoc_sent_r;
	reg [11:0] eoc_tx_r;
	reg [7:0]  tx_m4_act_r;
	reg [2:0]  tx_m56_act_r;
	reg [7:0]  rx_m4_sf_r;
	reg [2:0]  rx_m56_sf_r;
	reg [7:0]  tll_cand_r;
	reg [15:0] tll_cnt_r;
	reg [7:0]  tll_val_r;
	reg [7:0]  pend_m4_r;
	reg [2:0]  pend_m56_r;
	reg        pend_v_r;
	reg [7:0]  rpt_m4_r;
	reg [2:0]  rpt_m56_r;
	reg [8:0]  eoc_sh_r;
	reg [11:0] eoc_last_r;
	reg [11:0] eoc_cand_r;
	reg [1:0]  eoc_cnt_r;
	reg [11:0] eoc_acc_r;
	reg [`MCE_LOG_AW-1:0] log_wptr_r;
	reg        wr_pend_r;
	reg        rd_log_r;
	reg [7:0]  dp_addr_r;

	wire       synced   = in_sync(line_state);
	wire       sf_end   = bf_strobe && (bf_idx == `MCE_BF_LAST);
	wire [3:0] nidx_w   = {1'b0, bf_idx} + 4'h1;
	wire [2:0] nidx     = nidx_w[2:0];
	wire [3:0] cnt_base = {bf_idx, 1'b0};
	wire       rx_m4    = rx_mbits[2];
	wire [1:0] cur_cnt  = tll_cnt_r[cnt_base +: 2];
	wire [1:0] new_cnt  = (rx_m4 == tll_cand_r[bf_idx]) ?
		sat_inc(cur_cnt) : 2'h1;
	wire [2:0] eoc_mode = filt_r[`MCE_F_EOC];
	wire       m4_crc   = filt_r[`MCE_F_M4CRC];

	// ----------------------------------------
	// Per-bit triple confirmation of M4
	// ----------------------------------------
	reg [7:0] tll_val_nxt;
	always @* begin
		tll_val_nxt = tll_val_r;
		if (bf_strobe && new_cnt == `MCE_TLL_CNT) begin
			tll_val_nxt[bf_idx] = rx_m4; // [RULE24] [RULE1]
		end
	end

	// ----------------------------------------
	// System-side validation at superframe end
	// ----------------------------------------
	wire [7:0] sf_m4  = {rx_m4, rx_m4_sf_r[6:0]};
	wire [7:0] cand4  = filt_r[`MCE_F_M4TLL] ? tll_val_nxt : sf_m4;
	reg  [7:0] rpt_m4_nxt;
	reg  [2:0] rpt_m56_nxt;
	always @* begin
		rpt_m4_nxt  = rpt_m4_r;
		rpt_m56_nxt = rpt_m56_r;
		if (m4_crc) begin
			if (pend_v_r && crc_ok) begin
				rpt_m4_nxt = pend_m4_r; // [RULE26]
			end
			if (pend_v_r) begin
				rpt_m56_nxt = pend_m56_r;
			end
		end else begin
			rpt_m4_nxt  = cand4;
			rpt_m56_nxt = rx_m56_sf_r;
		end
		if (filt_r[`MCE_F_M56OC]) begin
			rpt_m56_nxt = rx_m56_sf_r;
		end
	end
	wire ob_chg = (|((rpt_m4_nxt ^ rpt_m4_r) & rxmask_r)) || // [RULE7]
		(rpt_m56_nxt != rpt_m56_r);

	// ----------------------------------------
	// EOC receive assembly and checks
	// ----------------------------------------
	wire [11:0] eoc_msg   = {eoc_sh_r, rx_mbits[5:3]};
	wire        eoc_done  = bf_strobe && (bf_idx[1:0] == `MCE_MSG_LAST);
	wire [1:0]  eoc_ncnt  = (eoc_msg == eoc_cand_r) ?
		sat_inc(eoc_cnt_r) : 2'h1;
	wire        eoc_conf  = (eoc_ncnt == `MCE_TLL_CNT) &&
		(eoc_cnt_r == `MCE_TLL_PRE);
	wire        eoc_echo  = eoc_sent_r && (eoc_msg == eoc_tx_r);
	reg         eoc_issue;
	always @* begin
		eoc_issue = 1'b0;
		if (eoc_mode == `MCE_EOC_AUTO) begin
			eoc_issue = eoc_conf && (eoc_echo || // [RULE20] [RULE16]
				eoc_msg != eoc_acc_r); // [RULE21] [RULE19]
		end else if (eoc_mode == `MCE_EOC_TRANS) begin
			eoc_issue = 1'b1; // [RULE22]
		end else if (eoc_mode == `MCE_EOC_ONCHG) begin
			eoc_issue = (eoc_msg != eoc_last_r); // [RULE23]
		end else if (eoc_mode == `MCE_EOC_TRTLL) begin
			eoc_issue = eoc_conf && (eoc_msg != eoc_acc_r);
		end
	end

	// ----------------------------------------
	// Transmit M-bits for the next basic frame
	// ----------------------------------------
	wire [7:0] tx_m4_now  = (sf_end) ? ob_m4(ob_cmd_r) : tx_m4_act_r;
	wire [2:0] tx_m56_now = (sf_end) ? {ob_cmd_r[9], ob_cmd_r[7],
		ob_cmd_r[10]} : tx_m56_act_r;
	wire       eoc_load   = nidx[1:0] == `MCE_MSG_FIRST;
	wire [11:0] eoc_tx_now = eoc_load ? eoc_cmd_r : eoc_tx_r;
	wire [2:0] tx_trip    = synced ? trip(eoc_tx_now, nidx[1:0]) :
		`MCE_TRIP_ONES; // [RULE17] [RULE12]
	wire       tx_m4      = txmask_r[nidx] ? fsm_tx_m4[nidx] :
		tx_m4_now[nidx]; // [RULE4] [RULE5]
	wire       tx_m5      = (nidx == `MCE_BF_FIRST) ? tx_m56_now[0] :
		(nidx == `MCE_BF_SECOND) ? tx_m56_now[1] : 1'b1; // [RULE10]
	wire       tx_m6      = (nidx == `MCE_BF_FIRST) ? tx_m56_now[2] : 1'b1;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_mbits_r   <= {`MCE_TRIP_ONES, `MCE_TRIP_ONES};
			tx_m4_act_r  <= `MCE_M4_ONES;
			tx_m56_act_r <= `MCE_M56_ONES;
			eoc_tx_r     <= `MCE_EOC_IDLE;
			eoc_sent_r   <= 1'b0;
		end else if (bf_strobe) begin
			tx_mbits_r   <= {tx_trip, tx_m4, tx_m5, tx_m6};
			tx_m4_act_r  <= tx_m4_now; // [RULE9]
			tx_m56_act_r <= tx_m56_now;
			eoc_tx_r     <= eoc_tx_now; // [RULE18]
			if (eoc_load && eoc_new_r) begin
				eoc_sent_r <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Receive collection, validation, reports
	// ----------------------------------------
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_m4_sf_r      <= `MCE_M4_ONES;
			rx_m56_sf_r     <= `MCE_M56_ONES;
			tll_cand_r      <= `MCE_M4_ONES;
			tll_cnt_r       <= 16'h0000;
			tll_val_r       <= `MCE_M4_ONES;
			pend_m4_r       <= `MCE_M4_ONES;
			pend_m56_r      <= `MCE_M56_ONES;
			pend_v_r        <= 1'b0;
			rpt_m4_r        <= `MCE_M4_ONES;
			rpt_m56_r       <= `MCE_M56_ONES;
			ob_msg_valid_r  <= 1'b0;
			ob_msg_data_r   <= `MCE_EOC_IDLE;
			fsm_rx_m4_r     <= `MCE_M4_ONES;
		end else begin
			ob_msg_valid_r <= 1'b0;
			if (bf_strobe) begin
				rx_m4_sf_r[bf_idx]      <= rx_m4;
				tll_cand_r[bf_idx]      <= rx_m4;
				tll_cnt_r[cnt_base +: 2] <= new_cnt;
				tll_val_r               <= tll_val_nxt;
				if (bf_idx == `MCE_BF_FIRST) begin
					rx_m56_sf_r[0] <= rx_mbits[1];
					rx_m56_sf_r[2] <= rx_mbits[0];
				end else if (bf_idx == `MCE_BF_SECOND) begin
					rx_m56_sf_r[1] <= rx_mbits[1];
				end
			end
			if (sf_end) begin
				pend_m4_r  <= cand4;
				pend_m56_r <= rx_m56_sf_r;
				pend_v_r   <= m4_crc;
				rpt_m4_r   <= rpt_m4_nxt;
				rpt_m56_r  <= rpt_m56_nxt;
				if (ob_chg && synced) begin // [RULE2] [RULE11]
					ob_msg_valid_r <= 1'b1;
					ob_msg_data_r  <= ob_pack(rpt_m4_nxt, rpt_m56_nxt);
				end
			end
			// Shared filter waits for CRC, so FSM lags a superframe
			if (bf_strobe) begin
				if (filt_r[`MCE_F_FSMSEL]) begin
					fsm_rx_m4_r <= sf_end ? rpt_m4_nxt :
						rpt_m4_r; // [RULE3] [RULE25]
				end else begin
					fsm_rx_m4_r <= tll_val_nxt; // [RULE1]
				end
				if (!rxmask_r[`MCE_SAI_BIT]) begin
					fsm_rx_m4_r[`MCE_SAI_BIT] <= 1'b1; // [RULE8]
				end
			end
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			eoc_sh_r        <= 9'h1ff;
			eoc_last_r      <= `MCE_EOC_IDLE;
			eoc_cand_r      <= `MCE_EOC_IDLE;
			eoc_cnt_r       <= 2'h0;
			eoc_acc_r       <= `MCE_EOC_IDLE;
			eoc_msg_valid_r <= 1'b0;
			eoc_msg_data_r  <= `MCE_EOC_IDLE;
			log_wptr_r      <= {`MCE_LOG_AW{1'b0}};
		end else begin
			eoc_msg_valid_r <= 1'b0;
			if (bf_strobe && !eoc_done) begin
				eoc_sh_r <= {eoc_sh_r[5:0], rx_mbits[5:3]}; // [RULE12]
			end
			if (eoc_done) begin
				eoc_cand_r <= eoc_msg;
				eoc_cnt_r  <= eoc_ncnt; // [RULE24]
				eoc_last_r <= eoc_msg;
				if (eoc_conf) begin
					eoc_acc_r <= eoc_msg;
				end
				if (eoc_issue && synced) begin // [RULE11]
					eoc_msg_valid_r <= 1'b1;
					eoc_msg_data_r  <= eoc_msg; // [RULE13] [RULE14]
					log_wptr_r      <= log_wptr_r + 1'b1;
				end
			end
		end
	end

	// ----------------------------------------
	// AHB-Lite register slave
	// ----------------------------------------
	wire        ahb_go = hsel && htrans[1] && hready;
	wire [11:0] log_q;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			rd_log_r  <= 1'b0;
			dp_addr_r <= 8'h00;
		end else if (hready) begin
			wr_pend_r <= ahb_go && hwrite;
			rd_log_r  <= ahb_go && !hwrite &&
				(haddr[7:5] == `MCE_LOG_SEL);
			dp_addr_r <= haddr[7:0];
		end
	end

	// Straps are caught once, on the first edge after reset release
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			strap_done_r <= 1'b0;
			filt_r       <= 8'h00;
			txmask_r     <= `MCE_MASK_RST;
			rxmask_r     <= `MCE_MASK_RST;
			ob_cmd_r     <= `MCE_EOC_IDLE;
			eoc_cmd_r    <= `MCE_EOC_IDLE;
			eoc_new_r    <= 1'b0;
		end else begin
			if (bf_strobe && eoc_load) begin
				eoc_new_r <= 1'b0;
			end
			if (!strap_done_r) begin
				strap_done_r <= 1'b1;
				filt_r <= {crcon_pin ? `MCE_FILT_CRC_ON : `MCE_FILT_CRC_OF,
					auto_pin ? `MCE_EOC_AUTO : `MCE_EOC_TRANS};
			end else if (wr_pend_r) begin
				if (dp_addr_r == `MCE_A_FILT) begin
					filt_r <= hwdata[7:0]; // [RULE23] [RULE25]
				end else if (dp_addr_r == `MCE_A_TXMASK) begin
					txmask_r <= hwdata[7:0];
				end else if (dp_addr_r == `MCE_A_RXMASK) begin
					rxmask_r <= hwdata[7:0];
				end else if (dp_addr_r == `MCE_A_OBCMD) begin
					ob_cmd_r <= hwdata[11:0]; // [RULE10]
				end else if (dp_addr_r == `MCE_A_EOCCMD) begin
					eoc_cmd_r <= hwdata[11:0]; // [RULE15]
					eoc_new_r <= 1'b1;
				end else if (dp_addr_r == `MCE_A_SAICTL) begin
					txmask_r[`MCE_SAI_BIT] <= hwdata[0]; // [RULE5]
				end
			end
		end
	end

	reg [31:0] reg_rd;
	always @* begin
		reg_rd = 32'h0000_0000;
		if (dp_addr_r == `MCE_A_FILT) begin
			reg_rd[7:0] = filt_r;
		end else if (dp_addr_r == `MCE_A_TXMASK) begin
			reg_rd[7:0] = txmask_r;
		end else if (dp_addr_r == `MCE_A_RXMASK) begin
			reg_rd[7:0] = rxmask_r;
		end else if (dp_addr_r == `MCE_A_OBCMD) begin
			reg_rd[11:0] = ob_cmd_r;
		end else if (dp_addr_r == `MCE_A_EOCCMD) begin
			reg_rd[11:0] = eoc_cmd_r;
		end else if (dp_addr_r == `MCE_A_SAICTL) begin
			reg_rd[0] = txmask_r[`MCE_SAI_BIT];
		end else if (dp_addr_r == `MCE_A_STATUS) begin
			reg_rd[6:0] = {log_wptr_r, eoc_sent_r, pend_v_r, 1'b0,
				synced};
		end else if (dp_addr_r == `MCE_A_OBRPT) begin
			reg_rd[11:0] = ob_pack(rpt_m4_r, rpt_m56_r); // [RULE9]
		end else if (dp_addr_r == `MCE_A_EOCRPT) begin
			reg_rd[11:0] = eoc_acc_r;
		end
	end

	assign hrdata    = rd_log_r ? {20'h0_0000, log_q} : reg_rd;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	mce_log_ram u_log (
		.hclk    (hclk),
		.hresetn (hresetn),
		.we      (eoc_done && eoc_issue && synced),
		.waddr   (log_wptr_r),
		.wdata   (eoc_msg),
		.raddr   (haddr[4:2]),
		.rdata_r (log_q)
	);

endmodule

// [shared/mce_consts.vh]
`ifndef MCE_CONSTS_VH
`define MCE_CONSTS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define MCE_A_FILT      8'h00
`define MCE_A_TXMASK    8'h04
`define MCE_A_RXMASK    8'h08
`define MCE_A_OBCMD     8'h0c
`define MCE_A_EOCCMD    8'h10
`define MCE_A_SAICTL    8'h14
`define MCE_A_STATUS    8'h18
`define MCE_A_OBRPT     8'h1c
`define MCE_A_EOCRPT    8'h20
`define MCE_LOG_SEL     3'h2
`define MCE_LOG_AW      3
`define MCE_LOG_DEPTH   8

// ----------------------------------------
// Filter configuration fields
// ----------------------------------------
`define MCE_F_EOC       2:0
`define MCE_F_M4TLL     3
`define MCE_F_M4CRC     4
`define MCE_F_FSMSEL    5
`define MCE_F_M56OC     6
`define MCE_EOC_AUTO    3'h4
`define MCE_EOC_TRANS   3'h1
`define MCE_EOC_ONCHG   3'h2
`define MCE_EOC_TRTLL   3'h3
`define MCE_FILT_CRC_ON 5'h06
`define MCE_FILT_CRC_OF 5'h00

// ----------------------------------------
// M-bit layout and idle values
// ----------------------------------------
`define MCE_SAI_BIT     6
`define MCE_MASK_RST    8'hff
`define MCE_M4_ONES     8'hff
`define MCE_M56_ONES    3'h7
`define MCE_TRIP_ONES   3'h7
`define MCE_EOC_IDLE    12'hfff
`define MCE_TLL_CNT     2'h3
`define MCE_TLL_PRE     2'h2
`define MCE_BF_LAST     3'h7
`define MCE_BF_FIRST    3'h0
`define MCE_BF_SECOND   3'h1
`define MCE_MSG_LAST    2'h3
`define MCE_MSG_FIRST   2'h0

// ----------------------------------------
// EOC message fields and codes
// ----------------------------------------
`define MCE_EOC_ADDR    11:9
`define MCE_EOC_DM      8
`define MCE_EOC_INFO    7:0
`define MCE_ADR_NT      3'h0
`define MCE_ADR_BCAST   3'h7
`define MCE_DM_MSG      1'b1
`define MCE_DM_DATA     1'b0
`define MCE_C_LB_BOTH   8'h50
`define MCE_C_LB_B1     8'h51
`define MCE_C_LB_B2     8'h52
`define MCE_C_REQ_CRC   8'h53
`define MCE_C_NOT_CRC   8'h54
`define MCE_C_RTN       8'hff
`define MCE_C_HOLD      8'h00
`define MCE_C_UTC       8'haa

// ----------------------------------------
// Line states with a running superframe
// ----------------------------------------
`define MCE_ST_ACTIVE   4'h1
`define MCE_ST_PENDTR   4'h2
`define MCE_ST_STDEACT  4'h3
`define MCE_ST_PENDDEA  4'h4
`define MCE_ST_TRANSP   4'h5

`endif

// [src/mce_log_ram.v]
`timescale 1ns/100ps
`include "mce_consts.vh"

module mce_log_ram (
	// Clock and reset
	input  wire                    hclk,
	input  wire                    hresetn,
	// Write port
	input  wire                    we,
	input  wire [`MCE_LOG_AW-1:0]  waddr,
	input  wire [11:0]             wdata,
	// Read port
	input  wire [`MCE_LOG_AW-1:0]  raddr,
	output reg  [11:0]             rdata_r
);

	reg [11:0] mem [0:`MCE_LOG_DEPTH-1];

	always @(posedge hclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdata_r <= 12'h000;
		end else begin
			rdata_r <= mem[raddr];
		end
	end

endmodule

// [tb/mce_maint_core_props.sv]
`timescale 1ns/100ps

module mce_maint_props (
	// Clock and reset
	input wire       hclk,
	input wire       hresetn,
	// Bus answer
	input wire       hreadyout,
	input wire       hresp,
	// Frame side
	input wire       bf_strobe,
	input wire [2:0] bf_idx,
	input wire [3:0] line_state,
	input wire [5:0] tx_mbits_r,
	input wire [7:0] fsm_rx_m4_r,
	// Reports
	input wire       ob_msg_valid_r,
	input wire       eoc_msg_valid_r
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	wire sync = line_state >= 4'h1 && line_state <= 4'h5;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	bus_okay_a: assert property (hreadyout && !hresp)
		else $error("bus answer not ready and okay");
	ob_sync_a: assert property (ob_msg_valid_r |-> $past(sync))
		else $error("overhead report while unsynced");
	eoc_sync_a: assert property (eoc_msg_valid_r |-> $past(sync))
		else $error("eoc report while unsynced");
	ob_sf_a: assert property (ob_msg_valid_r |->
		$past(bf_strobe && bf_idx == 3'h7))
		else $error("overhead report before superframe end");
	eoc_slot_a: assert property (eoc_msg_valid_r |->
		$past(bf_strobe && bf_idx[1:0] == 2'h3))
		else $error("eoc report off a message boundary");
	eoc_idle_a: assert property (bf_strobe && !sync |=>
		tx_mbits_r[5:3] == 3'h7)
		else $error("eoc bits not high without superframe");
	tx_hold_a: assert property (!bf_strobe |=> $stable(tx_mbits_r))
		else $error("tx bits moved between frames");
	fsm_upd_a: assert property ($changed(fsm_rx_m4_r) |->
		$past(bf_strobe))
		else $error("state machine bits moved off a frame end");
endmodule

// [tb/mce_far_end.sv]
`timescale 1ns/100ps

module mce_far_end (
	// Clock and reset
	input  wire        hclk,
	input  wire        hresetn,
	// Content to send
	input  wire [11:0] msg_a,
	input  wire [11:0] msg_b,
	input  wire [7:0]  m4,
	input  wire [2:0]  spare,
	// Frame side
	output reg         bf_strobe,
	output reg  [2:0]  bf_idx,
	output reg  [5:0]  rx_mbits,
	output wire        crc_ok
);
	reg  [1:0]  ph_r;
	wire [2:0]  f = bf_idx + 3'h1;
	wire [11:0] m = f[2] ? msg_b : msg_a;
	wire [1:0]  q = 2'h3 - f[1:0];
	// CRC positions carry a changing filler
	wire [1:0]  m56 = f == 3'h0 ? spare[2:1] :
		f == 3'h1 ? {spare[0], 1'b1} : {f[0], ~f[0]};

	assign crc_ok = 1'b1;

	// Lines invert between strobes so stale bits never look valid
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_r      <= 2'h0;
			bf_strobe <= 1'b0;
			bf_idx    <= 3'h7;
			rx_mbits  <= 6'h3f;
		end else begin
			ph_r      <= ph_r + 2'h1;
			bf_strobe <= ph_r == 2'h3;
			if (ph_r == 2'h3) begin
				bf_idx   <= f;
				rx_mbits <= {m[3 * q +: 3], m4[f], m56};
			end else begin
				rx_mbits <= ~rx_mbits;
			end
		end
	end
endmodule

// [tb/mce_maint_core_tb_top.sv]
`timescale 1ns/100ps
`include "mce_consts.vh"

module mce_maint_core_tb_top;
	logic        hclk, hresetn, hsel, hwrite;
	logic [31:0] haddr, hwdata, rd, seed;
	logic [1:0]  htrans;
	logic [3:0]  line_state;
	logic [7:0]  fsm_tx_m4, m4, tm;
	logic [11:0] msg_a, msg_b, oc, ec;
	logic [2:0]  spare, f;
	wire         hreadyout, hresp, bf_strobe, crc_ok;
	wire         ob_msg_valid_r, eoc_msg_valid_r;
	wire  [31:0] hrdata;
	wire  [2:0]  bf_idx;
	wire  [5:0]  rx_mbits, tx_mbits_r;
	wire  [7:0]  fsm_rx_m4_r;
	wire  [11:0] ob_msg_data_r, eoc_msg_data_r;
	int          num_errors, samples_checked, n_ob, i, j;
	logic [11:0] eq[$];
	int          md[4] = '{`MCE_EOC_TRANS, `MCE_EOC_ONCHG,
		`MCE_EOC_TRTLL, `MCE_EOC_AUTO};
	int          cd[8] = '{`MCE_C_LB_BOTH, `MCE_C_LB_B1, `MCE_C_LB_B2,
		`MCE_C_REQ_CRC, `MCE_C_NOT_CRC, `MCE_C_RTN, `MCE_C_HOLD, `MCE_C_UTC};

	mce_maint_core mce_maint_core_inst (.hclk, .hresetn, .hsel, .haddr,
		.htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
		.hreadyout, .hresp, .hrdata, .auto_pin(1'b1), .crcon_pin(1'b0),
		.bf_strobe, .bf_idx, .rx_mbits, .crc_ok, .line_state, .fsm_tx_m4,
		.tx_mbits_r, .fsm_rx_m4_r, .ob_msg_valid_r, .ob_msg_data_r,
		.eoc_msg_valid_r, .eoc_msg_data_r);
	mce_far_end mce_far_end_inst (.hclk, .hresetn, .msg_a, .msg_b, .m4,
		.spare, .bf_strobe, .bf_idx, .rx_mbits, .crc_ok);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		return x ^ (x << 5);
	endfunction
	function automatic logic [11:0] obx(input logic [7:0] m,
		input logic [2:0] s);
		return {m[0], s[2:1], m[1], s[0], 1'b1, m[2], m[3], m[4], m[5],
			m[6], m[7]};
	endfunction
	task automatic results();
		if (num_errors == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			num_errors++;
			$display("CHECK FAILED %0t seen %h want %h", $time, s, e);
		end
	endtask
	task automatic rdy();
		int t;
		for (t = 0; t < 20; t++) begin
			@(posedge hclk);
			if (hreadyout === 1'b1)
				return;
		end
		num_errors++;
		results();
	endtask
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge hclk);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= {24'h0, a};
		hwrite <= w;
		rdy();
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rdy();
		rd = hrdata;
	endtask
	// Leaves f at the frame the outputs now describe
	task automatic frm();
		int t;
		@(negedge hclk);
		for (t = 0; t < 9 && bf_strobe !== 1'b1; t++)
			@(negedge hclk);
		if (t == 9) begin
			num_errors++;
			results();
		end
		f = bf_idx + 3'h1;
		@(negedge hclk);
		if (eoc_msg_valid_r === 1'b1)
			eq.push_back(eoc_msg_data_r);
		n_ob += ob_msg_valid_r === 1'b1;
	endtask
	task automatic sf(input int n);
		int c;
		for (c = 0; c < n; c += f == 3'h0)
			frm();
	endtask
	task automatic rx(input logic [11:0] a, input logic [11:0] b);
		@(posedge hclk);
		msg_a <= a;
		msg_b <= b;
	endtask
	task automatic txsf();
		int k;
		for (k = 0; k < 8; k++) begin
			frm();
			chk(tx_mbits_r[5:3], ec[3 * (3 - f[1:0]) +: 3]);
			chk(tx_mbits_r[2], tm[f] ? fsm_tx_m4[f] :
				oc[f == 0 ? 11 : f == 1 ? 8 : 7 - f]);
			if (f == 3'h0)
				chk(tx_mbits_r[1:0], oc[10:9]);
			if (f == 3'h1)
				chk(tx_mbits_r[1], oc[7]);
		end
	endtask

	initial begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
		{line_state, fsm_tx_m4, n_ob, num_errors, samples_checked} = '0;
		{msg_a, msg_b, m4, spare} = '1;
		seed = 32'h0000_6a47;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(0, `MCE_A_FILT, 0);
		chk(rd, `MCE_EOC_AUTO);
		bus(0, `MCE_A_TXMASK, 0);
		chk(rd, `MCE_MASK_RST);
		bus(1, 8'h30, 32'hffff_ffff);
		bus(0, 8'h30, 0);
		chk(rd, 0);
		rx(12'h5a3, 12'h0c6);
		for (i = 0; i < 16; i++) begin
			frm();
			chk(tx_mbits_r[5:3], 3'h7);
		end
		chk(eq.size() + n_ob, 0);
		seed = xs(seed);
		oc = seed[23:12];
		tm = seed[31:24];
		@(posedge hclk);
		line_state <= `MCE_ST_ACTIVE;
		fsm_tx_m4  <= seed[7:0];
		bus(1, `MCE_A_OBCMD, oc);
		bus(1, `MCE_A_TXMASK, tm);
		for (j = 0; j < 8; j++) begin
			seed = xs(seed);
			ec = {seed[2:0], `MCE_DM_MSG, cd[j][7:0]};
			bus(1, `MCE_A_EOCCMD, ec);
			sf(1);
			txsf();
		end
		tm[6] = ~tm[6];
		bus(1, `MCE_A_SAICTL, tm[6]); // no local loop applied
		bus(0, `MCE_A_TXMASK, 0);
		chk(rd, tm);
		sf(1);
		txsf();
		for (j = 0; j < 4; j++) begin
			bus(1, `MCE_A_FILT, md[j]);
			seed = xs(seed);
			rx(seed[11:0], seed[11:0]);
			sf(3);
			eq.delete();
			sf(1);
			chk(eq.size(), j == 0 ? 2 : 0);
			rx(seed[23:12], seed[23:12]);
			sf(2);
			chk(eq.size(), j == 0 ? 6 : 1);
			chk(eq[$], seed[23:12]);
		end
		seed = xs(seed);
		ec = seed[11:0];
		bus(1, `MCE_A_EOCCMD, ec);
		rx(ec, ec);
		sf(3);
		eq.delete();
		rx(~ec, ec);
		sf(1);
		rx(ec, ec);
		sf(2);
		chk(eq.size(), 1);
		chk(eq[0], ec);
		bus(1, `MCE_A_RXMASK, 8'hff);
		seed = xs(seed);
		@(posedge hclk);
		m4    <= seed[7:0] & 8'hbf;
		spare <= seed[10:8];
		sf(5);
		chk(fsm_rx_m4_r, m4);
		chk(ob_msg_data_r, obx(m4, spare));
		n_ob = 0;
		@(posedge hclk);
		m4 <= m4 ^ 8'h01;
		sf(1);
		chk(n_ob, 1);
		chk(ob_msg_data_r, obx(m4, spare));
		bus(1, `MCE_A_RXMASK, 8'h3e);
		@(posedge hclk);
		m4 <= m4 ^ 8'h01;
		n_ob = 0;
		sf(5);
		chk(n_ob, 0);
		chk(fsm_rx_m4_r[6], 1'b1);
		chk(fsm_rx_m4_r[0], m4[0]);
		// CRC filter shared with the state machine
		bus(1, `MCE_A_RXMASK, 8'hff);
		bus(1, `MCE_A_FILT, 8'h34);
		sf(2);
		@(posedge hclk);
		m4 <= m4 ^ 8'h02;
		n_ob = 0;
		sf(1);
		chk(n_ob, 0);
		chk(fsm_rx_m4_r, m4 ^ 8'h02);
		sf(1);
		chk(n_ob, 1);
		chk(fsm_rx_m4_r, m4);
		chk(ob_msg_data_r, obx(m4, spare));
		bus(0, `MCE_A_STATUS, 0);
		chk(rd[3:0], 4'hd);
		bus(0, 8'h40 + {rd[6:4] - 3'h1, 2'h0}, 0);
		chk(rd, ec);
		results();
	end
endmodule

bind mce_maint_core mce_maint_props mce_maint_props_inst (.hclk, .hresetn,
	.hreadyout, .hresp, .bf_strobe, .bf_idx, .line_state, .tx_mbits_r,
	.fsm_rx_m4_r, .ob_msg_valid_r, .eoc_msg_valid_r);
